// ---- rtl/mas_pkg.sv ----
package mas_pkg;

  // register offsets on the serial management bus
  localparam logic [7:0] REG_AUX_VALUE    = 8'h21;
  localparam logic [7:0] REG_SUPPLY_VALUE = 8'h22;
  localparam logic [7:0] REG_REMOTE1_TEMP = 8'h25;
  localparam logic [7:0] REG_LOCAL_TEMP   = 8'h26;
  localparam logic [7:0] REG_REMOTE2_TEMP = 8'h27;
  localparam logic [7:0] REG_FAN1_SELECT  = 8'h55;
  localparam logic [7:0] REG_CONFIG_TWO   = 8'h73;
  localparam logic [7:0] REG_EXT_RES_TWO  = 8'h77;

  // reset values
  localparam logic [7:0] FAN1_SELECT_RST  = 8'h00;
  localparam logic [7:0] CONFIG_TWO_RST   = 8'h00;

  // configuration two fields
  localparam int CFG_AVG_OFF_BIT   = 4;
  localparam int CFG_BYPASS_BIT    = 5;
  localparam int CFG_SINGLE_BIT    = 6;
  // channel selector field in register 0x55
  localparam int SEL_MSB           = 7;
  localparam int SEL_LSB           = 5;

  // channel selector codes
  typedef enum logic [2:0] {
    CH_AUX     = 3'b001,
    CH_SUPPLY  = 3'b010,
    CH_REMOTE1 = 3'b101,
    CH_LOCAL   = 3'b110,
    CH_REMOTE2 = 3'b111
  } mas_chan_e;

  // averaging and number formats
  localparam int            AVG_COUNT      = 16;
  localparam int            AVG_SHIFT      = 4;
  localparam logic [9:0]    CODE_FULL      = 10'h3ff;
  localparam logic [9:0]    OFFSET64_CODE  = 10'h100;
  localparam logic [9:0]    TWOS_MAX_CODE  = 10'h1ff;
  localparam logic [9:0]    TWOS_FAULT     = 10'h200;
  localparam logic [9:0]    EXT_FAULT      = 10'h000;

  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CONV_PERIOD_NS = 711_000;
  localparam int CONV_CYCLES    = CONV_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// ---- rtl/mas_monitor_adc_sequencer.sv ----
`timescale 1ns/100ps

// Overview of operation
// - by default sixteen conversions are averaged before a value is stored
// - averaging-off bit stores every single conversion, one per period
// - bypass bit removes the attenuator on the auxiliary supply input
// - single-channel bit converts selected channel only; round robin pointer chan_q keeps stepping unseen
// - single-channel mode converts the selected input every 711 us
// - channel selector lives in bits 7:5 of register 0x55
// - selector 001 is auxiliary supply, 010 is own supply
// - selector 101 remote one, 110 local, 111 remote two
// - voltages are 10-bit straight binary, saturating at 1023
// - upper eight bits of local temperature appear at 0x26
// - temperatures stored as twos complement or offset-64 binary
// - quarter-degree resolution, up to 127 or 191 degrees
// - two low bits of each temperature go to register 0x77
// - offset format puts 0 degrees at 0x40, all-zero flags fault
// - averaged voltage measurement takes sixteen periods, about 11.38 ms
module mas_monitor_adc_sequencer #(
  parameter int         CONV_CYCLES = mas_pkg::CONV_CYCLES,
  parameter logic [6:0] SLAVE_ADDR  = 7'h2e
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // serial management bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // converter control
  output logic            conv_start_o,
  output logic [2:0]      conv_chan_o,
  output logic            atten_bypass_o,
  input  wire logic       conv_valid_i,
  input  wire logic [9:0] conv_data_i,
  input  wire logic       diode_fault_i,
  // temperature encoding select
  input  wire logic       temp_ext_format_i
);

  typedef enum logic [3:0] {
    BUS_IDLE  = 4'b0000,
    BUS_ADDR  = 4'b0001,
    BUS_AACK  = 4'b0010,
    BUS_CMD   = 4'b0011,
    BUS_CACK  = 4'b0100,
    BUS_WDAT  = 4'b0101,
    BUS_WACK  = 4'b0110,
    BUS_RDAT  = 4'b0111,
    BUS_RACK  = 4'b1000
  } mas_bus_e;

  logic [1:0]  scl_s_q, sda_s_q;
  logic        scl_d_q, sda_d_q;
  logic        scl_rise, scl_fall, bus_start, bus_stop;
  mas_bus_e    bus_st_q;
  logic [2:0]  bit_cnt_q;
  logic        byte_done_q, rd_q, mack_q;
  logic [7:0]  shift_q, tx_q, ptr_q, rdata;
  logic [7:0]  fan1_sel_q, cfg2_q;
  logic        wr_en;
  logic [9:0]  aux_q, supply_q, rem1_q, local_q, rem2_q;
  logic [31:0] tick_cnt_q;
  logic        tick, avg_off, single_mode;
  logic [2:0]  chan_q;
  logic [3:0]  avg_cnt_q;
  logic [13:0] acc_q, acc_sum;
  logic [9:0]  avg_val;
  logic        fault_q, last_sample;

  // next channel of the round robin
  function automatic logic [2:0] next_chan(input logic [2:0] c);
    unique case (c)
      mas_pkg::CH_AUX:     next_chan = mas_pkg::CH_SUPPLY;
      mas_pkg::CH_SUPPLY:  next_chan = mas_pkg::CH_REMOTE1;
      mas_pkg::CH_REMOTE1: next_chan = mas_pkg::CH_LOCAL;
      mas_pkg::CH_LOCAL:   next_chan = mas_pkg::CH_REMOTE2;
      default:             next_chan = mas_pkg::CH_AUX;
    endcase
  endfunction

  // offset-64 converter code into the stored temperature encoding
  function automatic logic [9:0] fmt_temp(input logic [9:0] raw,
                                          input logic       ext,
                                          input logic       flt);
    if (ext)
    begin
      fmt_temp = flt ? mas_pkg::EXT_FAULT : raw;
    end
    else if (flt || raw < mas_pkg::OFFSET64_CODE)
    begin
      fmt_temp = flt ? mas_pkg::TWOS_FAULT
                     : 10'(raw - mas_pkg::OFFSET64_CODE);
    end
    else
    begin
      // twos format tops out at +127.75 degrees
      fmt_temp = (raw - mas_pkg::OFFSET64_CODE > mas_pkg::TWOS_MAX_CODE)
               ? mas_pkg::TWOS_MAX_CODE
               : 10'(raw - mas_pkg::OFFSET64_CODE);
    end
  endfunction

  // pin synchronisers, then one more stage for edge detection
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
    end
  end

  assign scl_rise  = scl_s_q[1] & ~scl_d_q;
  assign scl_fall  = ~scl_s_q[1] & scl_d_q;
  assign bus_start = scl_s_q[1] & scl_d_q & ~sda_s_q[1] & sda_d_q;
  assign bus_stop  = scl_s_q[1] & scl_d_q & sda_s_q[1] & ~sda_d_q;
  assign wr_en     = (bus_st_q == BUS_WDAT) & scl_fall & byte_done_q;
  assign sda_o     = 1'b0;

  // register read mux
  always_comb
  begin
    unique case (ptr_q)
      mas_pkg::REG_AUX_VALUE:    rdata = aux_q[9:2];
      mas_pkg::REG_SUPPLY_VALUE: rdata = supply_q[9:2];
      mas_pkg::REG_REMOTE1_TEMP: rdata = rem1_q[9:2];
      mas_pkg::REG_LOCAL_TEMP:   rdata = local_q[9:2];
      mas_pkg::REG_REMOTE2_TEMP: rdata = rem2_q[9:2];
      mas_pkg::REG_FAN1_SELECT:  rdata = fan1_sel_q;
      mas_pkg::REG_CONFIG_TWO:   rdata = cfg2_q;
      mas_pkg::REG_EXT_RES_TWO:
        rdata = {rem2_q[1:0], local_q[1:0], rem1_q[1:0], 2'h0};
      default:                   rdata = 8'h00;
    endcase
  end

  // serial slave: byte receive, acknowledge and byte send
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_st_q    <= BUS_IDLE;
      bit_cnt_q   <= 3'h0;
      byte_done_q <= 1'b0;
      rd_q        <= 1'b0;
      mack_q      <= 1'b0;
      shift_q     <= 8'h00;
      tx_q        <= 8'h00;
      ptr_q       <= 8'h00;
      sda_oe_o    <= 1'b0;
    end
    else if (bus_start)
    begin
      bus_st_q    <= BUS_ADDR;
      bit_cnt_q   <= 3'h0;
      byte_done_q <= 1'b0;
      sda_oe_o    <= 1'b0;
    end
    else if (bus_stop)
    begin
      bus_st_q <= BUS_IDLE;
      sda_oe_o <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (bus_st_q == BUS_RACK)
      begin
        mack_q <= ~sda_s_q[1];
      end
      else if (bus_st_q == BUS_ADDR || bus_st_q == BUS_CMD ||
               bus_st_q == BUS_WDAT || bus_st_q == BUS_RDAT)
      begin
        shift_q     <= {shift_q[6:0], sda_s_q[1]};
        bit_cnt_q   <= 3'(bit_cnt_q + 3'h1);
        byte_done_q <= (bit_cnt_q == 3'h7);
      end
    end
    else if (scl_fall)
    begin
      unique case (bus_st_q)
        BUS_ADDR:
          if (byte_done_q)
          begin
            byte_done_q <= 1'b0;
            rd_q        <= shift_q[0];
            sda_oe_o    <= (shift_q[7:1] == SLAVE_ADDR);
            bus_st_q    <= (shift_q[7:1] == SLAVE_ADDR) ? BUS_AACK
                                                        : BUS_IDLE;
          end
        BUS_CMD:
          if (byte_done_q)
          begin
            byte_done_q <= 1'b0;
            ptr_q       <= shift_q;
            sda_oe_o    <= 1'b1;
            bus_st_q    <= BUS_CACK;
          end
        BUS_WDAT:
          if (byte_done_q)
          begin
            byte_done_q <= 1'b0;
            sda_oe_o    <= 1'b1;
            bus_st_q    <= BUS_WACK;
          end
        BUS_AACK, BUS_RACK:
          if (rd_q && (bus_st_q == BUS_AACK || mack_q))
          begin
            tx_q     <= rdata;
            sda_oe_o <= ~rdata[7];
            bus_st_q <= BUS_RDAT;
          end
          else
          begin
            sda_oe_o <= 1'b0;
            bus_st_q <= rd_q ? BUS_IDLE : BUS_CMD;
          end
        BUS_CACK:
        begin
          sda_oe_o <= 1'b0;
          bus_st_q <= BUS_WDAT;
        end
        BUS_WACK:
        begin
          sda_oe_o <= 1'b0;
          bus_st_q <= BUS_IDLE;
        end
        BUS_RDAT:
          if (byte_done_q)
          begin
            byte_done_q <= 1'b0;
            sda_oe_o    <= 1'b0;
            bus_st_q    <= BUS_RACK;
          end
          else
          begin
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_o <= ~tx_q[6];
          end
        BUS_IDLE:
          sda_oe_o <= 1'b0;
      endcase
    end
  end

  // writable registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fan1_sel_q <= mas_pkg::FAN1_SELECT_RST;
      cfg2_q     <= mas_pkg::CONFIG_TWO_RST;
    end
    else if (wr_en)
    begin
      if (ptr_q == mas_pkg::REG_FAN1_SELECT)
        fan1_sel_q <= shift_q;
      if (ptr_q == mas_pkg::REG_CONFIG_TWO)
        cfg2_q <= shift_q;
    end
  end

  assign avg_off        = cfg2_q[mas_pkg::CFG_AVG_OFF_BIT];
  assign single_mode    = cfg2_q[mas_pkg::CFG_SINGLE_BIT];
  assign atten_bypass_o = cfg2_q[mas_pkg::CFG_BYPASS_BIT];

  // conversion period timer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt_q <= 32'h0;
    else if (tick)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= 32'(tick_cnt_q + 32'h1);
  end

  assign tick = (tick_cnt_q == 32'(CONV_CYCLES - 1));

  // start pulse and channel presented to the converter
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      conv_start_o <= 1'b0;
      conv_chan_o  <= mas_pkg::CH_AUX;
    end
    else
    begin
      conv_start_o <= tick;
      if (tick)
        conv_chan_o <= single_mode
                     ? fan1_sel_q[mas_pkg::SEL_MSB:mas_pkg::SEL_LSB]
                     : chan_q;
    end
  end

  assign acc_sum     = 14'(acc_q + {4'h0, conv_data_i});
  assign last_sample = avg_off ||
                       (avg_cnt_q == 4'(mas_pkg::AVG_COUNT - 1));
  assign avg_val     = avg_off ? conv_data_i
                               : acc_sum[mas_pkg::AVG_SHIFT +: 10];

  // accumulation and round robin advance
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_q     <= 14'h0;
      avg_cnt_q <= 4'h0;
      fault_q   <= 1'b0;
      chan_q    <= mas_pkg::CH_AUX;
    end
    else if (conv_valid_i)
    begin
      if (last_sample)
      begin
        acc_q     <= 14'h0;
        avg_cnt_q <= 4'h0;
        fault_q   <= 1'b0;
        chan_q    <= next_chan(chan_q);
      end
      else
      begin
        acc_q     <= acc_sum;
        avg_cnt_q <= 4'(avg_cnt_q + 4'h1);
        fault_q   <= fault_q | diode_fault_i;
      end
    end
  end

  // result registers, written once per measurement
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aux_q    <= 10'h0;
      supply_q <= 10'h0;
      rem1_q   <= 10'h0;
      local_q  <= 10'h0;
      rem2_q   <= 10'h0;
    end
    else if (conv_valid_i && last_sample)
    begin
      unique case (conv_chan_o)
        mas_pkg::CH_AUX:     aux_q    <= avg_val;
        mas_pkg::CH_SUPPLY:  supply_q <= avg_val;
        mas_pkg::CH_REMOTE1: rem1_q   <= fmt_temp(avg_val,
                               temp_ext_format_i,
                               fault_q | diode_fault_i);
        mas_pkg::CH_LOCAL:   local_q  <= fmt_temp(avg_val,
                               temp_ext_format_i,
                               fault_q | diode_fault_i);
        mas_pkg::CH_REMOTE2: rem2_q   <= fmt_temp(avg_val,
                               temp_ext_format_i,
                               fault_q | diode_fault_i);
        default:             aux_q    <= aux_q;
      endcase
    end
  end

endmodule

// ---- tb/mas_adc_model.sv ----
`timescale 1ns/100ps

// converter and sensor stand-in, one answer per start
module mas_adc_model (
  // clock
  input  wire logic       clk_i,
  // conversion requests
  input  wire logic       start_i,
  input  wire logic [2:0] chan_i,
  // conversion answers
  output logic            valid_o,
  output logic [9:0]      data_o,
  output logic            fault_o
);
  logic [9:0] lvl [8];
  logic [9:0] wob;
  logic [4:0] cnt;
  logic [4:0] lat;
  logic [2:0] ch;
  logic       odd;
  logic       fault;

  // input levels per channel code, prompt answers
  initial
  begin
    lvl = '{10'h0, 10'h3ff, 10'h300, 10'h0, 10'h0, 10'h119, 10'h1e6, 10'h0c3};
    wob = 10'h0;
    cnt = 5'h0;
    lat = 5'h3;
    odd = 1'b0;
    fault = 1'b0;
    valid_o = 1'b0;
    data_o = 10'h0;
    fault_o = 1'b0;
  end

  // data toggles when idle so stale values never look valid
  always @(posedge clk_i)
  begin
    valid_o <= 1'b0;
    data_o  <= ~data_o;
    fault_o <= ~fault_o;
    if (start_i)
    begin
      cnt <= lat;
      ch  <= chan_i;
    end
    else if (cnt != 5'h0)
      cnt <= cnt - 5'h1;
    if (cnt == 5'h1)
    begin
      valid_o <= 1'b1;
      data_o  <= odd ? lvl[ch] ^ wob : lvl[ch];
      fault_o <= fault;
      odd     <= ~odd;
    end
  end
endmodule

// ---- tb/mas_sequencer_monitor.sv ----
`timescale 1ns/100ps

// pin level checks of sequencing and bus drive
module mas_sequencer_monitor #(
  parameter int CONV_CYCLES = 20
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // watched pins
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       conv_start_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic       atten_bypass_o
);
  logic [31:0] gap_q;
  logic        seen_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_start;
    conv_start_o;
  endsequence
  sequence s_quiet;
    !conv_start_o [*8];
  endsequence

  // cycles since the last start
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= conv_start_o ? 32'h0 : gap_q + 32'h1;
      seen_q <= seen_q | conv_start_o;
    end
  end

  AST_START_PULSE: assert property (s_start |=> s_quiet)
    else $error("start pulse too long or too close");
  AST_PERIOD: assert property
    (conv_start_o && seen_q |-> gap_q == CONV_CYCLES - 1)
    else $error("start spacing wrong");
  AST_NO_STALL: assert property (gap_q <= CONV_CYCLES + 2)
    else $error("conversions stopped");
  AST_CHAN_MOVE: assert property
    ($changed(conv_chan_o) |-> conv_start_o)
    else $error("channel moved without start");
  AST_BYPASS_MOVE: assert property
    ($changed(atten_bypass_o) |-> !scl_i)
    else $error("bypass moved outside bus low phase");
  AST_ACK_MOVE: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive moved while bus clock high");
  AST_OD_LOW: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  AST_ACK_BOUND: assert property
    (sda_oe_o |-> ##[1:300] !sda_oe_o)
    else $error("data pin held too long");
endmodule

bind mas_monitor_adc_sequencer mas_sequencer_monitor #(
  .CONV_CYCLES (CONV_CYCLES)
) u_mon (
  .clk_i          (clk_i),
  .rst_n_i        (rst_n_i),
  .scl_i          (scl_i),
  .sda_o          (sda_o),
  .sda_oe_o       (sda_oe_o),
  .conv_start_o   (conv_start_o),
  .conv_chan_o    (conv_chan_o),
  .atten_bypass_o (atten_bypass_o)
);

// ---- tb/testbench.sv ----
`timescale 1ns/100ps

// register bus driven bench for the sequencer
module testbench;
  localparam int         CYC = 20;
  localparam int         H   = 10;
  localparam logic [6:0] DEV = 7'h2e;
  localparam logic [7:0] RA [5] = '{8'h21, 8'h22, 8'h25, 8'h26, 8'h27};
  localparam logic [2:0] CH [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       scl     = 1'b1;
  logic       msda    = 1'b1;
  logic       ext     = 1'b1;
  logic       rbit;
  logic       sda_o;
  logic       sda_oe;
  logic       start;
  logic       bypass;
  logic       valid;
  logic       fault;
  logic [2:0] chan;
  logic [9:0] data;
  logic [7:0] rd_q;
  int         n_mismatch = 0;
  int         n_checks   = 0;
  int         cyc        = 0;
  wire        sda = msda & !sda_oe;

  // free clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  mas_monitor_adc_sequencer #(.CONV_CYCLES(CYC)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .conv_start_o(start),
    .conv_chan_o(chan), .atten_bypass_o(bypass), .conv_valid_i(valid),
    .conv_data_i(data), .diode_fault_i(fault), .temp_ext_format_i(ext));
  mas_adc_model m (
    .clk_i(clk_i), .start_i(start), .chan_i(chan),
    .valid_o(valid), .data_o(data), .fault_o(fault));

  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one bus bit, data moved well after clock fall
  task automatic clk_bit(input logic b);
    tick(2);
    msda = b;
    tick(H);
    scl = 1'b1;
    tick(H);
    rbit = sda;
    scl = 1'b0;
  endtask

  task automatic bus_start();
    msda = 1'b1;
    tick(H);
    scl = 1'b1;
    tick(H);
    msda = 1'b0;
    tick(H);
    scl = 1'b0;
  endtask

  task automatic bus_stop();
    tick(2);
    msda = 1'b0;
    tick(H);
    scl = 1'b1;
    tick(H);
    msda = 1'b1;
    tick(H);
  endtask

  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i]);
    clk_bit(1'b1);
    chk({7'h0, rbit}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_start();
    byte_out({DEV, 1'b0});
    byte_out(a);
    byte_out(d);
    bus_stop();
  endtask

  task automatic rd(input logic [7:0] a);
    bus_start();
    byte_out({DEV, 1'b0});
    byte_out(a);
    bus_start();
    byte_out({DEV, 1'b1});
    for (int i = 0; i < 8; i++)
    begin
      clk_bit(1'b1);
      rd_q = {rd_q[6:0], rbit};
    end
    clk_bit(1'b1);
    bus_stop();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_q, e);
  endtask

  // averaged code of a channel, encoded per format
  function automatic logic [9:0] code(input logic [2:0] c, input logic e);
    logic [10:0] s;
    s = {1'b0, m.lvl[c]} + {1'b0, m.lvl[c] ^ m.wob};
    code = (c[2] && !e) ? s[10:1] - mas_pkg::OFFSET64_CODE : s[10:1];
  endfunction

  // full round robin pass, then every result register
  task automatic round(input logic e);
    logic [9:0] v;
    logic [9:0] lo;
    ext = e;
    tick(2000);
    for (int i = 0; i < 5; i++)
    begin
      v = code(CH[i], e);
      lo = {lo[7:0], v[1:0]};
      rdc(RA[i], v[9:2]);
    end
    rdc(8'h77, {lo[1:0], lo[3:2], lo[5:4], 2'b00});
  endtask

  initial
  begin
    tick(3);
    rst_n_i = 1'b1;
    tick(4);
    rdc(8'h73, mas_pkg::CONFIG_TWO_RST);
    rdc(8'h55, mas_pkg::FAN1_SELECT_RST);
    rdc(8'h40, 8'h00);
    m.wob = 10'h008;
    round(1'b1);
    wr(8'h73, 8'h20);
    chk({7'h0, bypass}, 8'h01);
    rdc(8'h73, 8'h20);
    round(1'b0);
    ext = 1'b1;
    wr(8'h55, 8'hc5);
    rdc(8'h55, 8'hc5);
    wr(8'h73, 8'h50);
    tick(100);
    chk({5'h0, chan}, {5'h0, mas_pkg::CH_LOCAL});
    rd(8'h26);
    chk(rd_q | 8'h02, 8'h7b);
    m.wob = 10'h0;
    wr(8'h55, 8'h20);
    tick(100);
    chk({5'h0, chan}, {5'h0, mas_pkg::CH_AUX});
    rdc(8'h21, 8'hff);
    m.fault = 1'b1;
    m.lat = 5'hf;
    wr(8'h55, 8'hc0);
    tick(100);
    rdc(8'h26, 8'h00);
    ext = 1'b0;
    tick(100);
    rdc(8'h26, 8'h80);
    summarize();
  end
endmodule
